/* verilog/clock_error_fallback_status.sv */
// Clock error latching, fallback status and PLL status bank with APB slave.
// Assumes all status inputs except the raw multiplier PLL lock come from
// logic on clock; that one arrives from the analog PLL and is synchronised.
//
// Behaviour
// RULE1 - Transient error sets latched flag, which holds
// RULE2 - Latched flags feed the fallback logic
// RULE3 - Low byte: sclkx2, sclk, c2, c4, c16 pair, c8
// RULE4 - High byte: failsafe, dpll syncs, netrefs, frames
// RULE5 - Flags: one is error, reset to zero
// RULE6 - Write one clears flag; status bytes read-only
// RULE7 - Bit 7 shows fallback or failsafe state
// RULE8 - Bits 6:4 carry the fallback state code
// RULE9 - Bit 3 high when X set active
// RULE10 - Clock commands stay pending until frame sync
// RULE11 - Pending bits: go 2, clear 1, force 0
// RULE12 - Pending bit clears on its execution cycle
// RULE13 - Bit 7 raw unlock, bit 6 threshold flag
// RULE14 - Threshold flag after unlock exceeds threshold
// RULE15 - Digital PLL one state, never code 11
// RULE16 - Digital PLL two state, same encoding
// RULE17 - Bit 1 high while connection memory resets
// RULE18 - Bit 0 gives active data memory page
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module clock_error_fallback_status (
	// Clock, reset, enable
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clockEnable,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Transient clock errors
	input  wire logic [7:0]  transientErrLow,
	input  wire logic [7:0]  transientErrHigh,
	// Latched errors toward the fallback machine
	output logic [7:0]       errLatchedLow,
	output logic [7:0]       errLatchedHigh,
	// Fallback machine status
	input  wire logic [2:0]  fallbackStateCode,
	input  wire logic        inFallbackFlag,
	input  wire logic        activeClockSetSel,
	// Clock commands and frame sync
	input  wire logic        goCmdIssue,
	input  wire logic        clearCmdIssue,
	input  wire logic        forceCmdIssue,
	input  wire logic        frameSync,
	output logic             goCmdExec,
	output logic             clearCmdExec,
	output logic             forceCmdExec,
	// PLL and memory status
	input  wire logic        multPllUnlockedPin,
	input  wire logic [1:0]  digPllOneLockState,
	input  wire logic [1:0]  digPllTwoLockState,
	input  wire logic        connMemResetActive,
	input  wire logic        activeDataPage,
	// Interrupt
	output logic             irq
);
	// Latched error bytes
	logic [7:0]  errLowReg;
	logic [7:0]  errLowNext;
	logic [7:0]  errHighReg;
	logic [7:0]  errHighNext;
	// Pending commands {go, clear, force}
	logic [2:0]  pendingReg;
	logic [2:0]  pendingNext;
	logic [2:0]  execReg;
	// Raw unlock synchroniser and filtered value
	logic        unlockSync1Reg;
	logic        unlockSync2Reg;
	logic        unlockSync3Reg;
	logic        unlockStableReg;
	// Unlock duration counter and threshold flag
	logic [15:0] unlockCountReg;
	logic [15:0] unlockCountNext;
	logic        thrFlagReg;
	logic        thrFlagNext;
	logic [15:0] unlockThrReg;
	// Registered copies of status inputs
	logic [2:0]  stateCodeReg;
	logic        inFallbackReg;
	logic        xySelReg;
	logic [1:0]  dp1Reg;
	logic [1:0]  dp2Reg;
	logic        cmrReg;
	logic        pageReg;
	// Interrupt status and mask
	logic [4:0]  intStatusReg;
	logic [4:0]  intStatusNext;
	logic [4:0]  intMaskReg;
	logic [4:0]  intEvents;
	// Read data register
	logic [31:0] prdataReg;

	// Zero wait states: an access ends in its first access cycle,
	// and a low enable simply stretches it
	// Bus phase decode
	wire         setupPhase  = psel & ~penable;
	wire         accessDone  = psel & penable & clockEnable;
	wire         writeDone   = accessDone & pwrite;
	wire         readDone    = accessDone & ~pwrite;
	wire         lane0       = pstrb[0];
	wire         lane1       = pstrb[1];

	// Address decode for the error answer; the read mux uses the register selects
	function automatic logic isMapped(input logic [11:0] addr);
		isMapped = (addr == clk_status_pkg::ADDR_ERR_LOW) ||
		           (addr == clk_status_pkg::ADDR_ERR_HIGH) ||
		           (addr == clk_status_pkg::ADDR_FB_STATUS) ||
		           (addr == clk_status_pkg::ADDR_PLL_STATUS) ||
		           (addr == clk_status_pkg::ADDR_INT_STATUS) ||
		           (addr == clk_status_pkg::ADDR_INT_MASK) ||
		           (addr == clk_status_pkg::ADDR_UNLOCK_THR);
	endfunction : isMapped

	// Invalid code 11 is folded onto fast correction
	function automatic logic [1:0] lockCode(input logic [1:0] raw);
		lockCode = (raw == clk_status_pkg::DPLL_INVALID) ?
		           clk_status_pkg::DPLL_FAST : raw;
	endfunction : lockCode

	// Register selects
	wire selErrLow  = (paddr == clk_status_pkg::ADDR_ERR_LOW);
	wire selErrHigh = (paddr == clk_status_pkg::ADDR_ERR_HIGH);
	wire selFb      = (paddr == clk_status_pkg::ADDR_FB_STATUS);
	wire selPll     = (paddr == clk_status_pkg::ADDR_PLL_STATUS);
	wire selIntStat = (paddr == clk_status_pkg::ADDR_INT_STATUS);
	wire selIntMask = (paddr == clk_status_pkg::ADDR_INT_MASK);
	wire selThr     = (paddr == clk_status_pkg::ADDR_UNLOCK_THR);
	wire mapped     = isMapped(paddr);

	// Status byte assembly
	wire [7:0] fbStatusByte = {
		inFallbackReg,                         // [RULE7]
		stateCodeReg,                          // [RULE8]
		xySelReg,                              // [RULE9]
		pendingReg                             // [RULE11]
	};
	wire [7:0] pllStatusByte = {
		unlockStableReg,                       // [RULE13]
		thrFlagReg,                            // [RULE13]
		dp1Reg,                                // [RULE15]
		dp2Reg,                                // [RULE16]
		cmrReg,                                // [RULE17]
		pageReg                                // [RULE18]
	};

	// Unmapped offsets read zero and only raise pslverr
	// Read mux; narrow registers sit low, upper bits read zero
	wire [31:0] readMux =
		selErrLow  ? {24'h000000, errLowReg} :
		selErrHigh ? {24'h000000, errHighReg} :
		selFb      ? {24'h000000, fbStatusByte} :
		selPll     ? {24'h000000, pllStatusByte} :
		selIntStat ? {27'h0000000, intStatusReg} :
		selIntMask ? {27'h0000000, intMaskReg} :
		selThr     ? {16'h0000, unlockThrReg} :
		32'h00000000;

	// Status bytes have no write path, so they stay read-only
	// without costing an error response [RULE6]
	// Write-one-to-clear strobes; status bytes ignore writes
	wire [7:0] clrLow  = (writeDone & selErrLow & lane0) ?
	                     pwdata[7:0] : 8'h00;     // [RULE6]
	wire [7:0] clrHigh = (writeDone & selErrHigh & lane0) ?
	                     pwdata[7:0] : 8'h00;     // [RULE6]

	// A new error wins over a clear in the same cycle
	always_comb begin
		errLowNext  = (errLowReg & ~clrLow) | transientErrLow;   // [RULE1]
		errHighNext = (errHighReg & ~clrHigh) | transientErrHigh; // [RULE1]
	end

	// Commands execute on frame sync; issue in that cycle waits again
	// Issue is OR-ed in after the clear so a command that meets a
	// frame sync in one cycle is never lost
	wire [2:0] issueVec = {goCmdIssue, clearCmdIssue, forceCmdIssue};
	wire [2:0] execVec  = frameSync ? pendingReg : 3'h0;     // [RULE10]
	always_comb begin
		pendingNext = (pendingReg & ~execVec) | issueVec;   // [RULE12]
	end

	// Unlock counter saturates, flag once count passes threshold
	// Limitation: a threshold of all ones can never be exceeded,
	// so the flag then stays low for good
	always_comb begin
		unlockCountNext = unlockCountReg;
		thrFlagNext     = 1'b0;
		if (unlockStableReg) begin
			if (unlockCountReg != 16'hffff) begin
				unlockCountNext = unlockCountReg + 16'h0001;
			end
			thrFlagNext = (unlockCountReg > unlockThrReg); // [RULE14]
		end else begin
			unlockCountNext = 16'h0000;
		end
	end

	// Interrupt events, read clear loses to a new event
	// State change compares with the snapshot: one event per change
	always_comb begin
		intEvents = '0;
		intEvents[clk_status_pkg::INT_NEW_ERR_LOW] =
			|(transientErrLow & ~errLowReg);
		intEvents[clk_status_pkg::INT_NEW_ERR_HIGH] =
			|(transientErrHigh & ~errHighReg);
		intEvents[clk_status_pkg::INT_STATE_CHANGE] =
			(fallbackStateCode != stateCodeReg);
		intEvents[clk_status_pkg::INT_CMD_DONE] = |execVec;
		intEvents[clk_status_pkg::INT_UNLOCK_THR] = thrFlagNext & ~thrFlagReg;
		intStatusNext = intStatusReg;
		if (readDone && selIntStat) begin
			// Only bits that were returned are cleared
			intStatusNext = intStatusReg & ~prdataReg[4:0];
		end
		intStatusNext = intStatusNext | intEvents;
	end

	// Latched errors and pending commands
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			errLowReg  <= clk_status_pkg::RST_ERR_LOW;   // [RULE5]
			errHighReg <= clk_status_pkg::RST_ERR_HIGH;  // [RULE5]
			pendingReg <= clk_status_pkg::RST_PENDING;   // [RULE11]
			execReg    <= 3'h0;
		end else if (clockEnable) begin
			errLowReg  <= errLowNext;
			errHighReg <= errHighNext;
			pendingReg <= pendingNext;
			execReg    <= execVec;
		end
	end

	// Raw unlock pin: three flops, change taken when last two agree
	// First flop may go metastable; only the second flop reads it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			unlockSync1Reg  <= 1'b0;
			unlockSync2Reg  <= 1'b0;
			unlockSync3Reg  <= 1'b0;
			unlockStableReg <= 1'b0;
		end else if (clockEnable) begin
			unlockSync1Reg <= multPllUnlockedPin;
			unlockSync2Reg <= unlockSync1Reg;
			unlockSync3Reg <= unlockSync2Reg;
			if (unlockSync2Reg == unlockSync3Reg) begin
				unlockStableReg <= unlockSync3Reg;      // [RULE13]
			end
		end
	end

	// Unlock duration tracking
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			unlockCountReg <= 16'h0000;
			thrFlagReg     <= 1'b0;
		end else if (clockEnable) begin
			unlockCountReg <= unlockCountNext;
			thrFlagReg     <= thrFlagNext;
		end
	end

	// Status snapshots, one cycle behind their sources
	// One cycle of latency buys a read word that is consistent with
	// what the setup edge captures
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stateCodeReg  <= clk_status_pkg::FB_INITIAL; // [RULE8]
			inFallbackReg <= 1'b0;                       // [RULE7]
			xySelReg      <= 1'b0;
			dp1Reg        <= clk_status_pkg::DPLL_LOCKED;
			dp2Reg        <= clk_status_pkg::DPLL_LOCKED;
			cmrReg        <= 1'b0;                       // [RULE17]
			pageReg       <= 1'b0;
		end else if (clockEnable) begin
			stateCodeReg  <= fallbackStateCode;
			inFallbackReg <= inFallbackFlag;
			xySelReg      <= activeClockSetSel;
			dp1Reg        <= lockCode(digPllOneLockState); // [RULE15]
			dp2Reg        <= lockCode(digPllTwoLockState); // [RULE16]
			cmrReg        <= connMemResetActive;
			pageReg       <= activeDataPage;
		end
	end

	// Software-written mask and threshold
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			intMaskReg   <= clk_status_pkg::RST_INT_MASK;
			unlockThrReg <= clk_status_pkg::RST_UNLOCK_THR;
		end else if (clockEnable) begin
			if (writeDone && selIntMask && lane0) begin
				intMaskReg <= pwdata[4:0];
			end
			if (writeDone && selThr && lane0) begin
				unlockThrReg[7:0] <= pwdata[7:0];
			end
			if (writeDone && selThr && lane1) begin
				unlockThrReg[15:8] <= pwdata[15:8];
			end
		end
	end

	// Interrupt status
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			intStatusReg <= '0;
		end else if (clockEnable) begin
			intStatusReg <= intStatusNext;
		end
	end

	// Read data captured in setup, so access phase answers at once
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdataReg <= 32'h00000000;
		end else if (clockEnable && setupPhase) begin
			prdataReg <= pwrite ? 32'h00000000 : readMux;
		end
	end

	// Outputs
	assign prdata         = prdataReg;
	assign pready         = psel & penable & clockEnable;
	assign pslverr        = accessDone & ~mapped;
	assign errLatchedLow  = errLowReg;              // [RULE2] [RULE3]
	assign errLatchedHigh = errHighReg;             // [RULE2] [RULE4]
	assign goCmdExec      = execReg[2];
	assign clearCmdExec   = execReg[1];
	assign forceCmdExec   = execReg[0];
	assign irq            = |(intStatusReg & intMaskReg);
endmodule : clock_error_fallback_status
`default_nettype wire

/* verilog/clk_status_pkg.sv */
// Register map, field positions, reset values and codes of the clock
// error and fallback status bank.
// Assumes a 12-bit APB byte address with one aligned word per register.
`default_nettype none
package clk_status_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_ERR_LOW    = 10'h122;
	localparam logic [9:0]  IDX_ERR_HIGH   = 10'h123;
	localparam logic [9:0]  IDX_FB_STATUS  = 10'h124;
	localparam logic [9:0]  IDX_PLL_STATUS = 10'h125;
	localparam logic [11:0] ADDR_ERR_LOW    = {IDX_ERR_LOW, 2'b00};
	localparam logic [11:0] ADDR_ERR_HIGH   = {IDX_ERR_HIGH, 2'b00};
	localparam logic [11:0] ADDR_FB_STATUS  = {IDX_FB_STATUS, 2'b00};
	localparam logic [11:0] ADDR_PLL_STATUS = {IDX_PLL_STATUS, 2'b00};
	// Interrupt and threshold registers
	localparam logic [11:0] ADDR_INT_STATUS = 12'h4a0;
	localparam logic [11:0] ADDR_INT_MASK   = 12'h4a4;
	localparam logic [11:0] ADDR_UNLOCK_THR = 12'h4a8;
	// Reset values
	localparam logic [7:0]  RST_ERR_LOW    = 8'h00;
	localparam logic [7:0]  RST_ERR_HIGH   = 8'h00;
	localparam logic [4:0]  RST_INT_MASK   = 5'h00;
	localparam logic [15:0] RST_UNLOCK_THR = 16'h03e8;
	localparam logic [2:0]  RST_PENDING    = 3'h0;
	// Fallback status byte fields
	localparam int FB_IN_FALLBACK_BIT = 7;
	localparam int FB_STATE_MSB       = 6;
	localparam int FB_STATE_LSB       = 4;
	localparam int FB_XY_SEL_BIT      = 3;
	localparam int FB_GO_PEND_BIT     = 2;
	localparam int FB_CLEAR_PEND_BIT  = 1;
	localparam int FB_FORCE_PEND_BIT  = 0;
	// PLL status byte fields
	localparam int PLL_RAW_UNLOCK_BIT = 7;
	localparam int PLL_THR_FLAG_BIT   = 6;
	localparam int PLL_DP1_MSB        = 5;
	localparam int PLL_DP1_LSB        = 4;
	localparam int PLL_DP2_MSB        = 3;
	localparam int PLL_DP2_LSB        = 2;
	localparam int PLL_CMR_BIT        = 1;
	localparam int PLL_PAGE_BIT       = 0;
	// Interrupt status fields
	localparam int INT_NEW_ERR_LOW  = 0;
	localparam int INT_NEW_ERR_HIGH = 1;
	localparam int INT_STATE_CHANGE = 2;
	localparam int INT_CMD_DONE     = 3;
	localparam int INT_UNLOCK_THR   = 4;
	localparam int INT_WIDTH        = 5;
	// Fallback state codes
	localparam logic [2:0] FB_INITIAL      = 3'h7;
	localparam logic [2:0] FB_PRIMARY      = 3'h0;
	localparam logic [2:0] FB_TO_PRIMARY   = 3'h1;
	localparam logic [2:0] FB_SECONDARY    = 3'h2;
	localparam logic [2:0] FB_TO_SECONDARY = 3'h3;
	localparam logic [2:0] FB_FS_1         = 3'h4;
	localparam logic [2:0] FB_FS_2         = 3'h5;
	// Digital PLL lock codes
	localparam logic [1:0] DPLL_LOCKED  = 2'h0;
	localparam logic [1:0] DPLL_SLOW    = 2'h1;
	localparam logic [1:0] DPLL_FAST    = 2'h2;
	localparam logic [1:0] DPLL_INVALID = 2'h3;
endpackage : clk_status_pkg
`default_nettype wire

/* tb/clk_status_properties.sv */
// Port-level checker for the clock error and fallback status bank.
// Assumes it is bound onto clock_error_fallback_status, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module clk_status_properties (
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        clockEnable,
	// APB request side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	// Error flags and commands
	input wire logic [7:0]  transientErrLow,
	input wire logic [7:0]  transientErrHigh,
	input wire logic [7:0]  errLatchedLow,
	input wire logic [7:0]  errLatchedHigh,
	input wire logic        goCmdIssue,
	input wire logic        frameSync,
	input wire logic        goCmdExec,
	input wire logic        forceCmdExec
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Completing byte-lane-0 writes; only these may clear flags
	wire wrAny = psel && penable && pwrite && clockEnable && pstrb[0];
	wire wrLo  = wrAny && (paddr == clk_status_pkg::ADDR_ERR_LOW);
	wire wrHi  = wrAny && (paddr == clk_status_pkg::ADDR_ERR_HIGH);
	property p_set_low;
		clockEnable |=> (errLatchedLow & $past(transientErrLow))
			== $past(transientErrLow);
	endproperty
	a_set_low: assert property (p_set_low)
		else $error("low error not latched");
	property p_set_high;
		clockEnable |=> (errLatchedHigh & $past(transientErrHigh))
			== $past(transientErrHigh);
	endproperty
	a_set_high: assert property (p_set_high)
		else $error("high error not latched");
	property p_hold_low;
		clockEnable && !wrLo |=> (errLatchedLow & $past(errLatchedLow))
			== $past(errLatchedLow);
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("latched low flag lost");
	property p_clear_low;
		wrLo && transientErrLow == 8'h00 |=> errLatchedLow
			== ($past(errLatchedLow) & ~$past(pwdata[7:0]));
	endproperty
	a_clear_low: assert property (p_clear_low)
		else $error("low write-one-clear wrong");
	property p_clear_high;
		wrHi && transientErrHigh == 8'h00 |=> errLatchedHigh
			== ($past(errLatchedHigh) & ~$past(pwdata[7:0]));
	endproperty
	a_clear_high: assert property (p_clear_high)
		else $error("high write-one-clear wrong");
	property p_no_spont;
		clockEnable |=> (errLatchedLow & ~$past(errLatchedLow)
			& ~$past(transientErrLow)) == 8'h00;
	endproperty
	a_no_spont: assert property (p_no_spont)
		else $error("flag set without error");
	property p_go_exec;
		(goCmdIssue && clockEnable && !frameSync) ##1
			(frameSync && clockEnable) |=> goCmdExec;
	endproperty
	a_go_exec: assert property (p_go_exec)
		else $error("go command not executed");
	property p_exec_frame;
		$rose(forceCmdExec) |-> $past(frameSync);
	endproperty
	a_exec_frame: assert property (p_exec_frame)
		else $error("force executed off frame");
endmodule : clk_status_properties
bind clock_error_fallback_status clk_status_properties u_props (
	.clock(clock), .sys_rst(sys_rst), .clockEnable(clockEnable),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .transientErrLow(transientErrLow),
	.transientErrHigh(transientErrHigh), .errLatchedLow(errLatchedLow),
	.errLatchedHigh(errLatchedHigh), .goCmdIssue(goCmdIssue),
	.frameSync(frameSync), .goCmdExec(goCmdExec),
	.forceCmdExec(forceCmdExec)
);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the clock error and fallback status bank.
// Assumes the package and design are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;     // 100 MHz core clock
	logic        sys_rst = 1'b1;   // Sync reset
	logic        ce = 1'b1;        // Clock enable, dropped once
	logic        psel = 1'b0;      // APB controls
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq;
	logic [7:0]  tLo = 8'h00, tHi = 8'h00, eLo, eHi; // Error bytes
	logic [2:0]  fbCode = 3'h7;    // Fallback state input
	logic        inFb = 1'b0, xySel = 1'b0, fSync = 1'b0;
	logic [2:0]  cmdIss = 3'h0;    // Go, clear, force
	wire  [2:0]  cmdExe;           // Exec pulses, same order
	logic        unlk = 1'b0, cmr = 1'b0, page = 1'b0;
	logic [1:0]  dp1 = 2'h0, dp2 = 2'h0;
	logic [11:0] aLo = clk_status_pkg::ADDR_ERR_LOW;
	logic [11:0] aHi = clk_status_pkg::ADDR_ERR_HIGH;
	logic [11:0] aFb = clk_status_pkg::ADDR_FB_STATUS;
	logic [11:0] aPll = clk_status_pkg::ADDR_PLL_STATUS;
	logic [11:0] aInt = clk_status_pkg::ADDR_INT_STATUS;
	logic [31:0] rd;               // Last read word
	logic        err;              // Last pslverr
	int          numErrors = 0;
	int          nChecks = 0;
	always #5 clock = ~clock;
	clock_error_fallback_status DUT (
		.clock(clock), .sys_rst(sys_rst), .clockEnable(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .transientErrLow(tLo), .transientErrHigh(tHi),
		.errLatchedLow(eLo), .errLatchedHigh(eHi),
		.fallbackStateCode(fbCode), .inFallbackFlag(inFb),
		.activeClockSetSel(xySel), .goCmdIssue(cmdIss[2]),
		.clearCmdIssue(cmdIss[1]), .forceCmdIssue(cmdIss[0]),
		.frameSync(fSync), .goCmdExec(cmdExe[2]),
		.clearCmdExec(cmdExe[1]), .forceCmdExec(cmdExe[0]),
		.multPllUnlockedPin(unlk), .digPllOneLockState(dp1),
		.digPllTwoLockState(dp2), .connMemResetActive(cmr),
		.activeDataPage(page), .irq(irq)
	);
	task automatic summarize;
		if (numErrors == 0 && nChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			numErrors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask : rdchk
	// Reset values, read-only status and an unmapped hole
	task automatic s_reset;
		rdchk("errLo rst", aLo, 32'h0);
		rdchk("errHi rst", aHi, 32'h0);
		apb(1'b1, aFb, 32'hff);
		rdchk("fb rst", aFb, 32'h70);
		rdchk("pll rst", aPll, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("hole err", err, 1'b1);
		chk("hole data", rd, 32'h0);
	endtask : s_reset
	// Brief error latches, survives recovery, clears by write one
	task automatic s_latch;
		logic [11:0] a;
		logic [7:0]  v, w;
		for (int i = 0; i < 2; i++) begin
			a = i ? aHi : aLo;
			v = i ? 8'h3c : 8'ha5;
			w = i ? 8'h0c : 8'h81;
			if (i) tHi <= v; else tLo <= v;
			tick(1);
			tLo <= 8'h00;
			tHi <= 8'h00;
			tick(2);
			chk("latched port", i ? eHi : eLo, v);
			rdchk("latched", a, {24'h0, v});
			apb(1'b1, a, 32'h0);
			apb(1'b1, a, {24'h0, w});
			rdchk("w1c", a, {24'h0, v & ~w});
		end
	endtask : s_latch
	// Every fallback state code but 6, with flag and clock set toggling
	task automatic s_fb;
		for (int i = 0; i < 8; i++) begin
			if (i != 6) begin
				fbCode <= i[2:0];
				inFb <= i[0];
				xySel <= ~i[0];
				tick(2);
				rdchk("fb", aFb, {24'h0, i[0], i[2:0], ~i[0], 3'h0});
				chk("fb flags", {rd[7], rd[3]}, {i[0], ~i[0]});
			end
		end
	endtask : s_fb
	// Each command pends until a frame sync, then clears
	task automatic s_cmd;
		for (int k = 0; k < 3; k++) begin
			cmdIss <= 3'h1 << k;
			tick(1);
			cmdIss <= 3'h0;
			rdchk("pending", aFb, 32'hf0 | (32'h1 << k));
			fSync <= 1'b1;
			tick(1);
			fSync <= 1'b0;
			tick(1);
			chk("exec pulse", cmdExe, 32'h1 << k);
			rdchk("executed", aFb, 32'hf0);
		end
		cmdIss <= 3'h4;
		tick(1);
		cmdIss <= 3'h0;
		fSync <= 1'b1;
		tick(1);
		fSync <= 1'b0;
		rdchk("go at once", aFb, 32'hf0);
	endtask : s_cmd
	// Digital PLL codes, memory bits and the unlock threshold
	task automatic s_pll;
		logic [1:0] x1, x2;
		for (int i = 0; i < 4; i++) begin
			dp1 <= i[1:0];
			dp2 <= 2'h3 - i[1:0];
			cmr <= i[0];
			page <= i[1];
			tick(2);
			x1 = (i == 3) ? 2'h2 : i[1:0];
			x2 = (i == 0) ? 2'h2 : 2'h3 - i[1:0];
			rdchk("pll", aPll, {26'h0, x1, x2, i[0], i[1]});
			chk("mem bits", rd[1:0], {i[0], i[1]});
		end
		apb(1'b1, clk_status_pkg::ADDR_UNLOCK_THR, 32'h4);
		unlk <= 1'b1;
		tick(4);
		apb(1'b0, aPll, 32'h0);
		chk("thr early", rd[7:6], 2'h2);
		tick(20);
		apb(1'b0, aPll, 32'h0);
		chk("unlocked", rd[7:6], 2'h3);
		unlk <= 1'b0;
		tick(10);
		apb(1'b0, aPll, 32'h0);
		chk("relocked", rd[7:6], 2'h0);
	endtask : s_pll
	// New error raises the line only when unmasked; a read clears it
	task automatic s_irq;
		apb(1'b1, aLo, 32'hff);
		apb(1'b0, aInt, 32'h0);
		tLo <= 8'h01;
		tick(1);
		tLo <= 8'h00;
		tick(1);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, clk_status_pkg::ADDR_INT_MASK, 32'h1);
		tick(1);
		chk("irq raised", irq, 1'b1);
		apb(1'b0, aInt, 32'h0);
		chk("int status", rd[0], 1'b1);
		tick(1);
		chk("irq cleared", irq, 1'b0);
	endtask : s_irq
	// Low clock enable freezes state; an error then goes unlatched
	task automatic s_freeze;
		ce <= 1'b0;
		tLo <= 8'h10;
		tick(2);
		tLo <= 8'h00;
		ce <= 1'b1;
		tick(2);
		chk("frozen", eLo, 32'h01);
	endtask : s_freeze
	// Main sequence
	initial begin
		tick(12);
		sys_rst <= 1'b0;
		s_reset();
		s_latch();
		s_fb();
		s_cmd();
		s_pll();
		s_irq();
		s_freeze();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
